// ===== logic/tsd_regs.sv
// apb register bank for termination trims, swap timing and dither control
`timescale 1ns/1ps
// Overview of operation
// - four read/write trims, factory value after reset
// - shared sampling lasts four plus twice overlap
// - overlap field bits 4:0, reset 0x08
// - steering select delayed only during swaps
// - select delay field bits 4:0, reset 0x07
// - dither control bit 0 enables dither
// - bit 1 amplitude, bit 2 rounding error choice
module tsd_regs (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] trim_fuse_a,
    input wire logic [7:0] trim_fuse_b,
    input wire logic [7:0] trim_fuse_c,
    input wire logic [7:0] trim_fuse_d,
    input wire logic swap_start,
    output logic [7:0] termination_trim_a,
    output logic [7:0] termination_trim_b,
    output logic [7:0] termination_trim_c,
    output logic [7:0] termination_trim_d,
    output logic shared_sample,
    output logic steer_select,
    output logic swap_busy,
    output logic dither_enable,
    output logic dither_amplitude_select,
    output logic rounding_error_select
);
    logic [7:0] trim_reg [tsd_pkg::NUM_TRIM];
    logic [7:0] trim_next [tsd_pkg::NUM_TRIM];
    logic [7:0] fuse_s2_reg [tsd_pkg::NUM_TRIM];
    logic [7:0] fuse_in [tsd_pkg::NUM_TRIM];
    logic [1:0] load_cnt_reg, load_cnt_next;
    logic loaded_reg, loaded_next;
    logic [7:0] overlap_reg, overlap_next;
    logic [7:0] steer_dly_reg, steer_dly_next;
    logic [7:0] dither_reg, dither_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic shared_int, steer_int, busy_int;
    logic shared_reg, steer_reg, busy_reg;
    tsd_pkg::tsd_sel_type sel;
    logic [1:0] trim_idx;
    logic wr_fire;

    assign fuse_in[0] = trim_fuse_a;
    assign fuse_in[1] = trim_fuse_b;
    assign fuse_in[2] = trim_fuse_c;
    assign fuse_in[3] = trim_fuse_d;

    function automatic tsd_pkg::tsd_sel_type decode(input logic [11:0] addr);
        if (addr[1:0] != 2'b00) begin
            decode = tsd_pkg::SEL_NONE;
        end else begin
            case (addr[11:2])
                tsd_pkg::IDX_TRIM_A, tsd_pkg::IDX_TRIM_B,
                tsd_pkg::IDX_TRIM_C, tsd_pkg::IDX_TRIM_D: decode = tsd_pkg::SEL_TRIM;
                tsd_pkg::IDX_OVERLAP: decode = tsd_pkg::SEL_OVERLAP;
                tsd_pkg::IDX_STEER: decode = tsd_pkg::SEL_STEER;
                tsd_pkg::IDX_DITHER: decode = tsd_pkg::SEL_DITHER;
                default: decode = tsd_pkg::SEL_NONE;
            endcase
        end
    endfunction : decode

    function automatic logic [31:0] zext(input logic [7:0] val);
        zext = {24'h00_0000, val};
    endfunction : zext

    function automatic logic in_access(input logic sel_in, input logic en_in);
        in_access = sel_in && en_in;
    endfunction : in_access

    assign sel = decode(paddr);
    assign trim_idx = 2'(paddr[11:2] - tsd_pkg::IDX_TRIM_A);
    // write lands only at the edge that completes the access phase
    assign wr_fire = in_access(psel, penable) && pready_reg && pwrite && !pslverr_reg;

    // fuse pins come from outside, so two flops before use
    // fuse pins must hold from reset release; later changes are not reloaded
    genvar g;
    generate
        for (g = 0; g < tsd_pkg::NUM_TRIM; g++) begin : g_fuse
            // first stage private to its lane, read only by the second
            logic [7:0] s1_reg;
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    s1_reg <= tsd_pkg::RST_TRIM;
                    fuse_s2_reg[g] <= tsd_pkg::RST_TRIM;
                end else begin
                    s1_reg <= fuse_in[g];
                    fuse_s2_reg[g] <= s1_reg;
                end
            end
        end
    endgenerate

    always_comb begin
        load_cnt_next = load_cnt_reg;
        loaded_next = loaded_reg;
        for (int i = 0; i < tsd_pkg::NUM_TRIM; i++) begin
            trim_next[i] = trim_reg[i];
        end
        overlap_next = overlap_reg;
        steer_dly_next = steer_dly_reg;
        dither_next = dither_reg;
        if (!loaded_reg) begin
            // writes before the load are dropped without an error
            if (load_cnt_reg == tsd_pkg::FUSE_LOAD_CNT) begin
                loaded_next = 1'b1;
                for (int i = 0; i < tsd_pkg::NUM_TRIM; i++) begin
                    trim_next[i] = fuse_s2_reg[i];
                end
            end else begin
                load_cnt_next = load_cnt_reg + 2'h1;
            end
        end else if (wr_fire) begin
            // reserved bits are stored as written; software keeps them zero
            case (sel)
                tsd_pkg::SEL_TRIM: trim_next[trim_idx] = pwdata[7:0];
                tsd_pkg::SEL_OVERLAP: overlap_next = pwdata[7:0];
                tsd_pkg::SEL_STEER: steer_dly_next = pwdata[7:0];
                tsd_pkg::SEL_DITHER: dither_next = pwdata[7:0];
                default: dither_next = dither_reg;
            endcase
        end
    end

    always_comb begin
        prdata_next = prdata_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        // one wait state so read data and pready leave flops
        if (in_access(psel, penable) && !pready_reg) begin
            pready_next = 1'b1;
            pslverr_next = (sel == tsd_pkg::SEL_NONE);
            case (sel)
                tsd_pkg::SEL_TRIM: prdata_next = zext(trim_reg[trim_idx]);
                tsd_pkg::SEL_OVERLAP: prdata_next = zext(overlap_reg);
                tsd_pkg::SEL_STEER: prdata_next = zext(steer_dly_reg);
                tsd_pkg::SEL_DITHER: prdata_next = zext(dither_reg);
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            load_cnt_reg <= 2'h0;
            loaded_reg <= 1'b0;
            for (int i = 0; i < tsd_pkg::NUM_TRIM; i++) begin
                trim_reg[i] <= tsd_pkg::RST_TRIM;
            end
            overlap_reg <= tsd_pkg::RST_OVERLAP;
            steer_dly_reg <= tsd_pkg::RST_STEER;
            dither_reg <= tsd_pkg::RST_DITHER;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            shared_reg <= 1'b0;
            steer_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            load_cnt_reg <= load_cnt_next;
            loaded_reg <= loaded_next;
            for (int i = 0; i < tsd_pkg::NUM_TRIM; i++) begin
                trim_reg[i] <= trim_next[i];
            end
            overlap_reg <= overlap_next;
            steer_dly_reg <= steer_dly_next;
            dither_reg <= dither_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            shared_reg <= shared_int;
            steer_reg <= steer_int;
            busy_reg <= busy_int;
        end
    end

    tsd_swap_timer u_swap (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .swap_start(swap_start),
        .overlap(overlap_reg[tsd_pkg::FIELD_MSB:tsd_pkg::FIELD_LSB]),
        .select_delay(steer_dly_reg[tsd_pkg::FIELD_MSB:tsd_pkg::FIELD_LSB]),
        .shared_sample(shared_int),
        .steer_select(steer_int),
        .swap_busy(busy_int)
    );

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign termination_trim_a = trim_reg[0];
    assign termination_trim_b = trim_reg[1];
    assign termination_trim_c = trim_reg[2];
    assign termination_trim_d = trim_reg[3];
    // extra stage keeps every top output on a flop; shifts swap outputs by one cycle
    assign shared_sample = shared_reg;
    assign steer_select = steer_reg;
    assign swap_busy = busy_reg;
    assign dither_enable = dither_reg[tsd_pkg::DITH_EN_BIT];
    assign dither_amplitude_select = dither_reg[tsd_pkg::DITH_AMP_BIT];
    assign rounding_error_select = dither_reg[tsd_pkg::DITH_ERR_BIT];
endmodule : tsd_regs

// ===== logic/tsd_pkg.sv
// constants for the trim, swap and delay register bank
package tsd_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int FIELD_W = 5;
    localparam int NUM_TRIM = 4;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_TRIM_A = 10'h07e;
    localparam logic [9:0] IDX_TRIM_B = 10'h07f;
    localparam logic [9:0] IDX_TRIM_C = 10'h080;
    localparam logic [9:0] IDX_TRIM_D = 10'h081;
    localparam logic [9:0] IDX_OVERLAP = 10'h09a;
    localparam logic [9:0] IDX_STEER = 10'h09b;
    localparam logic [9:0] IDX_DITHER = 10'h09d;
    localparam logic [7:0] RST_TRIM = 8'h00;
    localparam logic [7:0] RST_OVERLAP = 8'h08;
    localparam logic [7:0] RST_STEER = 8'h07;
    localparam logic [7:0] RST_DITHER = 8'h00;
    localparam int FIELD_LSB = 0;
    localparam int FIELD_MSB = 4;
    localparam int DITH_EN_BIT = 0;
    localparam int DITH_AMP_BIT = 1;
    localparam int DITH_ERR_BIT = 2;
    // shared sampling lasts base plus twice the overlap field
    localparam logic [6:0] SHARE_BASE = 7'h04;
    // fuse inputs settle through the synchroniser before being loaded
    localparam logic [1:0] FUSE_LOAD_CNT = 2'h2;
    typedef enum logic [2:0] {
        SEL_NONE, SEL_TRIM, SEL_OVERLAP, SEL_STEER, SEL_DITHER
    } tsd_sel_type;
    typedef enum logic {TSD_IDLE, TSD_SWAP} tsd_state_type;
endpackage : tsd_pkg

// ===== logic/tsd_swap_timer.sv
// swap timing: shared-sampling window and delayed steering select
`timescale 1ns/1ps
module tsd_swap_timer (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic swap_start,
    input wire logic [4:0] overlap,
    input wire logic [4:0] select_delay,
    output logic shared_sample,
    output logic steer_select,
    output logic swap_busy
);
    tsd_pkg::tsd_state_type state_reg, state_next;
    logic [6:0] share_cnt_reg, share_cnt_next;
    logic [4:0] sel_cnt_reg, sel_cnt_next;
    logic sel_done_reg, sel_done_next;
    logic shared_reg, shared_next;
    logic steer_reg, steer_next;

    always_comb begin
        state_next = state_reg;
        share_cnt_next = share_cnt_reg;
        sel_cnt_next = sel_cnt_reg;
        sel_done_next = sel_done_reg;
        shared_next = shared_reg;
        steer_next = steer_reg;
        case (state_reg)
            tsd_pkg::TSD_IDLE: begin
                // a start during a running swap is ignored
                if (swap_start) begin
                    state_next = tsd_pkg::TSD_SWAP;
                    shared_next = 1'b1;
                    share_cnt_next = tsd_pkg::SHARE_BASE + {1'b0, overlap, 1'b0} - 7'h01;
                    sel_cnt_next = select_delay;
                    sel_done_next = 1'b0;
                end
            end
            tsd_pkg::TSD_SWAP: begin
                if (share_cnt_reg != 7'h00) begin
                    share_cnt_next = share_cnt_reg - 7'h01;
                end else begin
                    shared_next = 1'b0;
                end
                if (!sel_done_reg) begin
                    if (sel_cnt_reg == 5'h00) begin
                        steer_next = ~steer_reg;
                        sel_done_next = 1'b1;
                    end else begin
                        sel_cnt_next = sel_cnt_reg - 5'h01;
                    end
                end
                if (sel_done_reg && !shared_reg) begin
                    state_next = tsd_pkg::TSD_IDLE;
                end
            end
            default: begin
                state_next = tsd_pkg::TSD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= tsd_pkg::TSD_IDLE;
            share_cnt_reg <= 7'h00;
            sel_cnt_reg <= 5'h00;
            sel_done_reg <= 1'b0;
            shared_reg <= 1'b0;
            steer_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            share_cnt_reg <= share_cnt_next;
            sel_cnt_reg <= sel_cnt_next;
            sel_done_reg <= sel_done_next;
            shared_reg <= shared_next;
            steer_reg <= steer_next;
        end
    end

    assign shared_sample = shared_reg;
    assign steer_select = steer_reg;
    assign swap_busy = (state_reg == tsd_pkg::TSD_SWAP);
endmodule : tsd_swap_timer

// ===== sim/tsd_regs_chk.sv
// assertions on the ports of the trim, swap and delay register bank
`timescale 1ns/1ps
module tsd_regs_chk (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic swap_start,
    input wire logic shared_sample,
    input wire logic steer_select,
    input wire logic swap_busy,
    input wire logic dither_enable,
    input wire logic dither_amplitude_select,
    input wire logic rounding_error_select
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [7:0] run_reg;
    logic [7:0] run_next;
    logic [4:0] ov_reg;
    logic [4:0] ov_next;
    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite && !pslverr;
    // shadow of the overlap field, so the window length can be tied to it
    always_comb begin
        run_next = shared_sample ? run_reg + 8'h01 : 8'h00;
        ov_next = (wr_done && paddr == 12'h268) ? pwdata[4:0] : ov_reg;
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            run_reg <= 8'h00;
            ov_reg <= 5'h08;
        end else begin
            run_reg <= run_next;
            ov_reg <= ov_next;
        end
    end
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_ready_wait: assert property (psel && !penable |-> ##2 pready) else $error("pready not after one wait");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error answer");
    a_read_upper: assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("read upper bits set");
    a_swap_begin: assert property (swap_start && !swap_busy |-> ##2 shared_sample && swap_busy)
        else $error("swap did not begin");
    a_shared_min: assert property ($rose(shared_sample) |-> shared_sample[*4]) else $error("window short");
    a_shared_len: assert property ($fell(shared_sample) |-> run_reg == 8'h04 + {2'h0, ov_reg, 1'h0})
        else $error("window length wrong");
    a_shared_busy: assert property (shared_sample |-> swap_busy) else $error("window outside swap");
    a_steer_idle: assert property (!swap_busy && !$past(swap_busy) |-> $stable(steer_select))
        else $error("select moved outside swap");
    a_dither_map: assert property (wr_done && paddr == 12'h274 |=> ##1
        {rounding_error_select, dither_amplitude_select, dither_enable} == $past(pwdata[2:0], 2))
        else $error("dither outputs wrong");
endmodule : tsd_regs_chk

bind tsd_regs tsd_regs_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .swap_start(swap_start), .shared_sample(shared_sample), .steer_select(steer_select), .swap_busy(swap_busy),
    .dither_enable(dither_enable), .dither_amplitude_select(dither_amplitude_select),
    .rounding_error_select(rounding_error_select));

// ===== sim/test_tsd_regs.sv
// self-checking bench for the trim, swap and delay register bank
`timescale 1ns/1ps
module test_tsd_regs;
    logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, swap_start, e;
    logic shared_sample, steer_select, swap_busy, d_en, d_amp, d_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] fuse [4];
    logic [7:0] trim [4];
    logic [9:0] idx [7];
    logic [7:0] exp_v [7];
    logic [7:0] wr_v [7];
    int bad_count, n_tests;

    tsd_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trim_fuse_a(fuse[0]), .trim_fuse_b(fuse[1]), .trim_fuse_c(fuse[2]), .trim_fuse_d(fuse[3]),
        .swap_start(swap_start), .termination_trim_a(trim[0]), .termination_trim_b(trim[1]),
        .termination_trim_c(trim[2]), .termination_trim_d(trim[3]), .shared_sample(shared_sample),
        .steer_select(steer_select), .swap_busy(swap_busy), .dither_enable(d_en),
        .dither_amplitude_select(d_amp), .rounding_error_select(d_err));

    task automatic end_sim();
        $display("compares %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (pready !== 1'h1) begin
            bad_count++;
            end_sim();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // idle edge so the next call never re-drives psel in this time step
        @(posedge clk_sys);
    endtask : apb

    task automatic swap(input logic [4:0] ov, input logic [4:0] dl);
        logic st0, win;
        int cnt, tog, k;
        apb(1'h1, 12'h268, {27'h000_0000, ov});
        apb(1'h1, 12'h26c, {27'h000_0000, dl});
        @(posedge clk_sys);
        st0 = steer_select;
        cnt = 0;
        tog = 0;
        win = 1'h0;
        swap_start <= 1'h1;
        @(posedge clk_sys);
        swap_start <= 1'h0;
        for (k = 1; k < 90; k++) begin
            @(posedge clk_sys);
            // a second start mid-swap must be ignored
            swap_start <= (k == 10 && ov > 5'h04);
            if (shared_sample === 1'h1) cnt++;
            if (steer_select !== st0 && tog == 0) begin
                tog = k;
                win = shared_sample;
            end
        end
        chk(cnt, 4 + 2 * ov);
        chk(tog, 3 + dl);
        chk({31'h0000_0000, win}, 32'(dl + 2 <= 4 + 2 * ov));
        chk({31'h0000_0000, swap_busy}, 32'h0000_0000);
        $display("swap test done");
    endtask : swap

    initial begin
        clk_sys = 1'h0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        #100000;
        bad_count++;
        end_sim();
    end

    initial begin
        sys_rst = 1'h1;
        {psel, penable, pwrite, swap_start} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        fuse = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
        idx = '{tsd_pkg::IDX_TRIM_A, tsd_pkg::IDX_TRIM_B, tsd_pkg::IDX_TRIM_C, tsd_pkg::IDX_TRIM_D,
            tsd_pkg::IDX_OVERLAP, tsd_pkg::IDX_STEER, tsd_pkg::IDX_DITHER};
        exp_v = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h08, 8'h07, 8'h00};
        // reserved bits of the delay and dither registers stay zero
        wr_v = '{8'he5, 8'he4, 8'he7, 8'he6, 8'h1b, 8'h14, 8'h05};
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'h0;
        repeat (6) @(posedge clk_sys);
        for (int i = 0; i < 7; i++) begin
            apb(1'h0, {idx[i], 2'h0}, 32'h0000_0000);
            chk(rd, {24'h00_0000, exp_v[i]});
        end
        $display("reset test done");
        for (int i = 0; i < 7; i++) apb(1'h1, {idx[i], 2'h0}, {24'hff_ff00, wr_v[i]});
        for (int i = 0; i < 7; i++) begin
            apb(1'h0, {idx[i], 2'h0}, 32'h0000_0000);
            chk(rd, {24'h00_0000, wr_v[i]});
            if (i < 4) chk({24'h00_0000, trim[i]}, {24'h00_0000, wr_v[i]});
        end
        $display("write test done");
        for (int v = 0; v < 8; v++) begin
            apb(1'h1, 12'h274, 32'(v));
            repeat (2) @(posedge clk_sys);
            chk({29'h0000_0000, d_err, d_amp, d_en}, 32'(v));
        end
        $display("dither test done");
        apb(1'h1, 12'hffc, 32'h0000_00aa);
        chk({31'h0000_0000, e}, 32'h0000_0001);
        apb(1'h0, 12'h1f9, 32'h0000_0000);
        chk({31'h0000_0000, e}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        $display("error test done");
        swap(5'h00, 5'h00);
        swap(5'h1f, 5'h1f);
        swap(5'h03, 5'h14);
        swap(5'h07, 5'h05);
        end_sim();
    end
endmodule : test_tsd_regs
